// >>> core/align_pkg.sv
/*
 Shared constants for the output alignment and reset control block:
 register offsets, field positions, reset values, timing counts, states.
 Assumes a 250 MHz channel-divider input clock drives the block.
*/
package align_pkg;
	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 8;
	localparam int NUM_CH     = 4;
	localparam int OUT_PER_CH = 3;
	localparam int NUM_OUT    = 12;
	localparam int CNT_W      = 4;

	localparam logic [11:0] A_SERIAL_CFG = 12'h000;
	localparam logic [11:0] A_OUT_CTL0   = 12'h0f0;
	localparam logic [11:0] A_DIV_MN0    = 12'h190;
	localparam int          DIV_STRIDE   = 3;
	localparam logic [11:0] A_DIST_CTL   = 12'h230;
	localparam logic [11:0] A_STATUS     = 12'h231;
	localparam logic [11:0] A_UPDATE     = 12'h232;

	localparam int SR_LO       = 2;
	localparam int SR_HI       = 5;
	localparam int OC_PD       = 0;
	localparam int OC_SWING_LO = 1;
	localparam int OC_INV      = 3;
	localparam int OC_CMOS     = 4;
	localparam int OC_EN_A     = 5;
	localparam int OC_EN_B     = 6;
	localparam int OC_INV_B    = 7;
	localparam int PH_BH       = 4;
	localparam int PH_SKIP     = 5;
	localparam int DC_PD       = 2;
	localparam int DS_SOFT_AL  = 0;
	localparam int DS_DIST_PD  = 1;
	localparam int UPD_BIT     = 0;

	localparam logic [7:0] SERIAL_CFG_RST = 8'h00;
	localparam logic [7:0] OUT_CTL_RST    = 8'h64;
	localparam logic [7:0] DIV_MN_RST     = 8'h00;
	localparam logic [7:0] DIV_PH_RST     = 8'h00;
	localparam logic [7:0] DIV_CTL_RST    = 8'h00;
	localparam logic [7:0] DIST_CTL_RST   = 8'h00;
	localparam logic [4:0] PIN_IDLE       = 5'h07;

	localparam int CLK_MHZ       = 250;
	localparam int POR_ALIGN_MS  = 50;
	localparam int POR_TOGGLE_MS = 70;
	localparam int HW_NVM_MS     = 20;
	localparam int HW_PLAIN_NS   = 2000;
	localparam int POR_ALIGN_CYC  = POR_ALIGN_MS * CLK_MHZ * 1000;
	localparam int POR_TOGGLE_CYC = POR_TOGGLE_MS * CLK_MHZ * 1000;
	localparam int HW_NVM_CYC     = HW_NVM_MS * CLK_MHZ * 1000;
	localparam int HW_PLAIN_CYC   = HW_PLAIN_NS * CLK_MHZ / 1000;
	localparam int SYNC_PIPE_CYC  = 14;
	localparam int TMR_W          = 26;

	typedef enum logic [3:0] {
		ST_POR  = 4'b0001,
		ST_HOLD = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_RUN  = 4'b1000
	} rst_state_e;
endpackage

// >>> core/channel_divider.sv
/*
 One channel divider with coarse phase offset and alignment preset.
 Assumes hold and start come from the same clock; start follows hold's release.
*/
`timescale 1ns/1ps
module channel_divider (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       hold,
	input  wire logic                       start,
	input  wire logic [align_pkg::CNT_W-1:0] low_cnt,
	input  wire logic [align_pkg::CNT_W-1:0] high_cnt,
	input  wire logic                       begin_high_flag,
	input  wire logic [3:0]                 phase_shift_field,
	output logic                            clk_out
);
	import align_pkg::*;

	logic [CNT_W-1:0] m_q;
	logic [CNT_W-1:0] n_q;
	logic [5:0]       delay;
	logic [5:0]       dcnt;
	logic [CNT_W-1:0] cnt;
	logic             armed;
	logic             run;
	logic [4:0]       phi;

	// Counts are latched only while held and offsets only at start, so new offsets wait for alignment
	always_comb begin
		phi = {begin_high_flag, phase_shift_field};
		if (phi <= 5'h0f)
			delay = {1'b0, phi};
		else
			// Real low count M is one above the stored field, so add two
			delay = {2'h0, phase_shift_field} + {2'h0, m_q} + 6'h02;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			clk_out <= 1'b0;
			m_q     <= '0;
			n_q     <= '0;
			dcnt    <= '0;
			cnt     <= '0;
			armed   <= 1'b0;
			run     <= 1'b1;
		end else if (hold) begin
			clk_out <= begin_high_flag;
			m_q     <= low_cnt;
			n_q     <= high_cnt;
			armed   <= 1'b0;
			run     <= 1'b0;
		end else if (start) begin
			armed <= 1'b1;
			dcnt  <= delay;
		end else if (armed) begin
			if (dcnt == 6'h00) begin
				armed   <= 1'b0;
				run     <= 1'b1;
				clk_out <= 1'b1;
				cnt     <= n_q;
			end else begin
				dcnt <= dcnt - 6'h01;
			end
		end else if (run) begin
			if (cnt == '0) begin
				clk_out <= ~clk_out;
				cnt     <= clk_out ? m_q : n_q;
			end else begin
				cnt <= cnt - 1'b1;
			end
		end
	end
endmodule

// >>> core/output_align_and_reset_control.sv
/*
 Output alignment, driver configuration and reset sequencing for four
 channel dividers feeding twelve grouped outputs.
 Assumes clk is the channel-divider input clock; pins are asynchronous.
*/
`timescale 1ns/1ps
module output_align_and_reset_control #(
	parameter int POR_ALIGN  = align_pkg::POR_ALIGN_CYC,
	parameter int POR_TOGGLE = align_pkg::POR_TOGGLE_CYC,
	parameter int HW_NVM     = align_pkg::HW_NVM_CYC
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic [align_pkg::ADDR_W-1:0] addr,
	input  wire logic [align_pkg::DATA_W-1:0] wdata,
	input  wire logic                         wr,
	input  wire logic                         rd,
	output logic      [align_pkg::DATA_W-1:0] rdata,
	input  wire logic                         sync_req_n,
	input  wire logic                         reset_req_n,
	input  wire logic                         sleep_request_n,
	input  wire logic                         nvm_select,
	input  wire logic                         sclk,
	input  wire logic                         vco_cal_busy,
	output logic                              nvm_load_req,
	output logic                              align_active,
	output logic      [align_pkg::NUM_OUT-1:0] diff_out,
	output logic      [align_pkg::NUM_OUT-1:0] diff_on,
	output logic      [align_pkg::NUM_OUT-1:0] diff_safe_pd,
	output logic                              diff_total_pd,
	output logic      [2*align_pkg::NUM_OUT-1:0] diff_swing,
	output logic      [align_pkg::NUM_OUT-1:0] cmos_a,
	output logic      [align_pkg::NUM_OUT-1:0] cmos_a_oe,
	output logic      [align_pkg::NUM_OUT-1:0] cmos_b,
	output logic      [align_pkg::NUM_OUT-1:0] cmos_b_oe
);
	import align_pkg::*;

	logic [4:0]        pin_s1;
	logic [4:0]        pin_s2;
	logic              sync_s;
	logic              reset_s;
	logic              sleep_s;
	logic              nvm_s;
	logic              sclk_s;
	logic              sclk_d;
	logic              sclk_rise;
	logic [7:0]        serial_cfg;
	logic [7:0]        out_ctl [NUM_OUT];
	logic [7:0]        div_reg [NUM_CH][DIV_STRIDE]; // Counts, phase, control
	logic [7:0]        dist_stage;
	logic [7:0]        dist_act;
	logic              soft_rst;
	logic              soft_set;
	logic              restore;
	logic              hit_out;
	logic [3:0]        out_idx;
	logic              hit_div;
	logic [1:0]        div_idx;
	logic [1:0]        div_sub;
	logic [7:0]        rd_mux;
	rst_state_e        state;
	logic [TMR_W-1:0]  tmr;
	logic [TMR_W-1:0]  wait_len;
	logic              align_req;
	logic              align_d;
	logic              pipe_busy;
	logic [4:0]        pipe_cnt;
	logic              restart;
	logic              quiet;
	logic [NUM_CH-1:0] ch_clk;

	// Order: {sclk, nvm_select, sleep, reset, sync}
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
			sclk_d <= 1'b0;
		end else begin
			pin_s1 <= {sclk, nvm_select, sleep_request_n, reset_req_n, sync_req_n};
			pin_s2 <= pin_s1;
			sclk_d <= sclk_s;
		end
	end

	assign {sclk_s, nvm_s, sleep_s, reset_s, sync_s} = pin_s2;
	assign sclk_rise = sclk_s & ~sclk_d;

	always_comb begin
		hit_out = 1'b0;
		out_idx = 4'h0;
		hit_div = 1'b0;
		div_idx = 2'h0;
		div_sub = 2'h0;
		for (int i = 0; i < NUM_OUT; i++) begin
			if (addr == A_OUT_CTL0 + ADDR_W'(i)) begin
				hit_out = 1'b1;
				out_idx = 4'(i);
			end
		end
		for (int c = 0; c < NUM_CH; c++) begin
			for (int s = 0; s < DIV_STRIDE; s++) begin
				if (addr == A_DIV_MN0 + ADDR_W'(c * DIV_STRIDE + s)) begin
					hit_div = 1'b1;
					div_idx = 2'(c);
					div_sub = 2'(s);
				end
			end
		end
	end

	assign soft_set = wr && addr == A_SERIAL_CFG && wdata[SR_LO] && wdata[SR_HI];
	assign restore  = (state == ST_HOLD) || soft_set;

	// Soft reset holds until a further rising serial clock edge; a new set wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			soft_rst <= 1'b0;
		else if (soft_set)
			soft_rst <= 1'b1;
		else if (sclk_rise)
			soft_rst <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			serial_cfg <= SERIAL_CFG_RST;
		else if (state == ST_HOLD)
			serial_cfg <= SERIAL_CFG_RST;
		else if (wr && addr == A_SERIAL_CFG) begin
			serial_cfg         <= wdata;
			serial_cfg[SR_LO]  <= 1'b0;
			serial_cfg[SR_HI]  <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_OUT; i++)
				out_ctl[i] <= OUT_CTL_RST;
			for (int c = 0; c < NUM_CH; c++)
				div_reg[c] <= '{DIV_MN_RST, DIV_PH_RST, DIV_CTL_RST};
			dist_stage <= DIST_CTL_RST;
			dist_act   <= DIST_CTL_RST;
		end else if (restore) begin
			for (int i = 0; i < NUM_OUT; i++)
				out_ctl[i] <= OUT_CTL_RST;
			for (int c = 0; c < NUM_CH; c++)
				div_reg[c] <= '{DIV_MN_RST, DIV_PH_RST, DIV_CTL_RST};
			dist_stage <= DIST_CTL_RST;
			dist_act   <= DIST_CTL_RST;
		end else if (wr) begin
			if (hit_out)
				out_ctl[out_idx] <= wdata;
			if (hit_div)
				div_reg[div_idx][div_sub] <= wdata;
			if (addr == A_DIST_CTL)
				dist_stage <= wdata;
			// Soft-align changes only reach the logic through the update command
			if (addr == A_UPDATE && wdata[UPD_BIT])
				dist_act <= dist_stage;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		if (addr == A_SERIAL_CFG) begin
			rd_mux        = serial_cfg;
			rd_mux[SR_LO] = soft_rst;
			rd_mux[SR_HI] = soft_rst;
		end else if (hit_out)
			rd_mux = out_ctl[out_idx];
		else if (hit_div)
			rd_mux = div_reg[div_idx][div_sub];
		else if (addr == A_DIST_CTL)
			rd_mux = dist_stage;
		else if (addr == A_STATUS)
			rd_mux = {state, 1'b0, pipe_busy, soft_rst, align_active};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (rd)
			rdata <= rd_mux;
		else
			rdata <= 8'h00;
	end

	// Power-on and pin reset sequencing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state    <= ST_POR;
			tmr      <= '0;
			wait_len <= '0;
		end else begin
			case (state)
				ST_POR: begin
					if (!reset_s)
						state <= ST_HOLD;
					else if (tmr == TMR_W'(POR_ALIGN - 1)) begin
						state    <= ST_WAIT;
						tmr      <= '0;
						wait_len <= TMR_W'(POR_TOGGLE - POR_ALIGN);
					end else
						tmr <= tmr + 1'b1;
				end
				ST_HOLD: begin
					if (reset_s) begin
						state    <= ST_WAIT;
						tmr      <= '0;
						wait_len <= nvm_s ? TMR_W'(HW_NVM) : TMR_W'(HW_PLAIN_CYC);
					end
				end
				ST_WAIT: begin
					if (!reset_s)
						state <= ST_HOLD;
					else if (tmr + 1'b1 >= wait_len)
						state <= ST_RUN;
					else
						tmr <= tmr + 1'b1;
				end
				ST_RUN: begin
					if (!reset_s)
						state <= ST_HOLD;
				end
				default: state <= ST_POR;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			nvm_load_req <= 1'b0;
		else
			nvm_load_req <= nvm_s && ((state == ST_POR && tmr == TMR_W'(4))
				|| (state == ST_HOLD && reset_s) || (soft_rst && sclk_rise));
	end

	assign quiet = (state != ST_RUN);

	// Any source holds the request; its release starts the restart pipeline
	assign align_req = !sync_s
		|| dist_act[DS_SOFT_AL] || dist_act[DS_DIST_PD]
		|| soft_rst
		|| !sleep_s || state == ST_POR || state == ST_HOLD
		|| vco_cal_busy;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			align_d   <= 1'b1;
			pipe_busy <= 1'b0;
			pipe_cnt  <= 5'h00;
			restart   <= 1'b0;
		end else begin
			align_d <= align_req;
			restart <= 1'b0;
			if (align_req) begin
				pipe_busy <= 1'b0;
			end else if (align_d) begin
				pipe_busy <= 1'b1;
				pipe_cnt  <= 5'h00;
			end else if (pipe_busy) begin
				// Counting 0 to SYNC_PIPE_CYC - 1 keeps the pipeline busy for exactly 14 cycles
				if (pipe_cnt == 5'(SYNC_PIPE_CYC - 1)) begin
					pipe_busy <= 1'b0;
					restart   <= 1'b1;
				end else
					pipe_cnt <= pipe_cnt + 5'h01;
			end
		end
	end

	assign align_active = align_req || pipe_busy || align_d;

	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			channel_divider u_div (
				.clk               (clk),
				.rst               (rst),
				.hold              (align_active && !div_reg[c][1][PH_SKIP]),
				.start             (restart && !div_reg[c][1][PH_SKIP]),
				.low_cnt           (div_reg[c][0][7:4]),
				.high_cnt          (div_reg[c][0][3:0]),
				.begin_high_flag   (div_reg[c][1][PH_BH]),
				.phase_shift_field (div_reg[c][1][3:0]),
				.clk_out           (ch_clk[c])
			);
		end
	endgenerate

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			diff_total_pd <= 1'b0;
		else
			diff_total_pd <= dist_act[DS_DIST_PD];
	end

	genvar o;
	generate
		for (o = 0; o < NUM_OUT; o++) begin : g_out
			logic [7:0] oc;
			logic       ch_pd;
			logic       safe;
			logic       src;
			logic       off;
			assign oc    = out_ctl[o];
			assign ch_pd = div_reg[o / OUT_PER_CH][2][DC_PD];
			assign safe  = oc[OC_PD] || ch_pd || !sleep_s;
			assign src   = ch_clk[o / OUT_PER_CH] && !ch_pd;
			assign off   = safe || dist_act[DS_DIST_PD] || quiet;

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					diff_out[o]         <= 1'b0;
					diff_on[o]          <= 1'b0;
					diff_safe_pd[o]     <= 1'b0;
					diff_swing[2*o +: 2] <= 2'h0;
					cmos_a[o]           <= 1'b0;
					cmos_a_oe[o]        <= 1'b0;
					cmos_b[o]           <= 1'b0;
					cmos_b_oe[o]        <= 1'b0;
				end else begin
					diff_out[o]         <= src ^ oc[OC_INV];
					diff_on[o]          <= !oc[OC_CMOS] && !off;
					diff_safe_pd[o]     <= safe && !dist_act[DS_DIST_PD];
					diff_swing[2*o +: 2] <= oc[OC_SWING_LO +: 2];
					cmos_a[o]           <= src ^ oc[OC_INV];
					cmos_b[o]           <= src ^ oc[OC_INV_B];
					cmos_a_oe[o]        <= oc[OC_CMOS] && oc[OC_EN_A] && !off;
					cmos_b_oe[o]        <= oc[OC_CMOS] && oc[OC_EN_B] && !off;
				end
			end
		end
	endgenerate
endmodule

// >>> verif/align_host_model.sv
/*
 Host controller model driving the alignment, reset, sleep, select and
 serial clock pins. Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module align_host_model (
	input  wire logic clk,
	output logic      sync_req_n,
	output logic      reset_req_n,
	output logic      sleep_request_n,
	output logic      nvm_select,
	output logic      sclk,
	output logic      vco_cal_busy
);
	initial begin
		sync_req_n      = 1'b1;
		reset_req_n     = 1'b1;
		sleep_request_n = 1'b1;
		nvm_select      = 1'b1;
		sclk            = 1'b0;
		vco_cal_busy    = 1'b0;
	end
	// Pin 0 alignment, 1 hard reset, 2 sleep, 3 calibration busy
	task automatic pulse_pin(input int which, input int cycles);
		@(posedge clk);
		case (which)
			0: sync_req_n <= 1'b0;
			1: reset_req_n <= 1'b0;
			2: sleep_request_n <= 1'b0;
			default: vco_cal_busy <= 1'b1;
		endcase
		repeat (cycles) @(posedge clk);
		sync_req_n      <= 1'b1;
		reset_req_n     <= 1'b1;
		sleep_request_n <= 1'b1;
		vco_cal_busy    <= 1'b0;
	endtask
	// Serial clock stays low between frames, so only this tick can end a soft reset
	task automatic serial_tick();
		@(posedge clk);
		sclk <= 1'b1;
		repeat (4) @(posedge clk);
		sclk <= 1'b0;
	endtask
	task automatic set_select(input logic v);
		@(posedge clk);
		nvm_select <= v;
	endtask
endmodule

// >>> verif/output_align_and_reset_control_props.sv
/*
 Concurrent checks on the ports of the output alignment and reset block.
 Assumes every pin request from the bench lasts at least four clocks.
*/
`timescale 1ns/1ps
module output_align_and_reset_control_props (
	input wire logic                          clk,
	input wire logic                          rst,
	input wire logic                          rd,
	input wire logic [align_pkg::DATA_W-1:0]  rdata,
	input wire logic                          sync_req_n,
	input wire logic                          reset_req_n,
	input wire logic                          sleep_request_n,
	input wire logic                          nvm_select,
	input wire logic                          vco_cal_busy,
	input wire logic                          nvm_load_req,
	input wire logic                          align_active,
	input wire logic [align_pkg::NUM_OUT-1:0] diff_on,
	input wire logic [align_pkg::NUM_OUT-1:0] diff_safe_pd,
	input wire logic                          diff_total_pd
);
	import align_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence pin_held;
		!sync_req_n [*4];
	endsequence
	sequence pin_release;
		pin_held ##1 sync_req_n;
	endsequence
	// The restart pipeline alone is 14 cycles, so the request cannot end sooner
	sequence pipe_runs;
		align_active [*8] ##1 align_active [*6];
	endsequence

	pin_hold_a: assert property (pin_held |-> align_active)
		else $error("alignment not requested while the pin is held low");
	sync_pipe_a: assert property (pin_release |-> pipe_runs)
		else $error("aligned restart came before the pipeline delay");
	sync_bound_a: assert property (pin_release |-> ##[14:60] !align_active)
		else $error("alignment did not end after the pin release");
	hard_hold_a: assert property (!reset_req_n [*4] |-> align_active)
		else $error("hard reset pin low without alignment");
	sleep_safe_a: assert property (!sleep_request_n [*5] |-> &diff_safe_pd)
		else $error("sleep without safe power-down on every driver");
	cal_hold_a: assert property (vco_cal_busy [*2] |-> align_active)
		else $error("calibration running without alignment request");
	total_off_a: assert property (diff_total_pd [*2] |-> diff_on == '0)
		else $error("driver left on during total power-down");
	nvm_pulse_a: assert property (nvm_load_req |-> nvm_select ##1 !nvm_load_req)
		else $error("settings load request with select low or too long");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == '0)
		else $error("read data outside the cycle after a read");
endmodule

bind output_align_and_reset_control output_align_and_reset_control_props props_i (
	.clk(clk), .rst(rst), .rd(rd), .rdata(rdata), .sync_req_n(sync_req_n),
	.reset_req_n(reset_req_n), .sleep_request_n(sleep_request_n), .nvm_select(nvm_select),
	.vco_cal_busy(vco_cal_busy), .nvm_load_req(nvm_load_req), .align_active(align_active),
	.diff_on(diff_on), .diff_safe_pd(diff_safe_pd), .diff_total_pd(diff_total_pd));

// >>> verif/tb_output_align_and_reset_control.sv
/*
 Self-checking bench for the output alignment and reset control block.
 Assumes the host model owns the pins and the bench owns the register port.
*/
`timescale 1ns/1ps
module tb_output_align_and_reset_control;
	import align_pkg::*;
	localparam int POR_A = 20;
	localparam int POR_T = 40;
	localparam int HW_N  = 30;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic [ADDR_W-1:0]    addr = '0;
	logic [DATA_W-1:0]    wdata = '0;
	logic                 wr = 1'b0;
	logic                 rd = 1'b0;
	logic [DATA_W-1:0]    rdata;
	logic                 sync_req_n;
	logic                 reset_req_n;
	logic                 sleep_request_n;
	logic                 nvm_select;
	logic                 sclk;
	logic                 vco_cal_busy;
	logic                 nvm_load_req;
	logic                 align_active;
	logic [NUM_OUT-1:0]   diff_out;
	logic [NUM_OUT-1:0]   diff_on;
	logic [NUM_OUT-1:0]   diff_safe_pd;
	logic                 diff_total_pd;
	logic [2*NUM_OUT-1:0] diff_swing;
	logic [NUM_OUT-1:0]   cmos_a;
	logic [NUM_OUT-1:0]   cmos_a_oe;
	logic [NUM_OUT-1:0]   cmos_b;
	logic [NUM_OUT-1:0]   cmos_b_oe;
	logic [7:0]           phase_tab [4] = '{8'h00, 8'h05, 8'h12, 8'h20};
	int                   failures = 0;
	int                   samples_checked = 0;

	always #2 clk = ~clk;

	output_align_and_reset_control #(.POR_ALIGN(POR_A), .POR_TOGGLE(POR_T), .HW_NVM(HW_N))
	output_align_and_reset_control_i (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.sync_req_n(sync_req_n), .reset_req_n(reset_req_n), .sleep_request_n(sleep_request_n),
		.nvm_select(nvm_select), .sclk(sclk), .vco_cal_busy(vco_cal_busy),
		.nvm_load_req(nvm_load_req), .align_active(align_active), .diff_out(diff_out),
		.diff_on(diff_on), .diff_safe_pd(diff_safe_pd), .diff_total_pd(diff_total_pd),
		.diff_swing(diff_swing), .cmos_a(cmos_a), .cmos_a_oe(cmos_a_oe), .cmos_b(cmos_b),
		.cmos_b_oe(cmos_b_oe));
	align_host_model align_host_model_i (
		.clk(clk), .sync_req_n(sync_req_n), .reset_req_n(reset_req_n),
		.sleep_request_n(sleep_request_n), .nvm_select(nvm_select), .sclk(sclk),
		.vco_cal_busy(vco_cal_busy));

	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_span(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic chk_reg(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		chk_val(rdata, e);
	endtask
	// Waits for drivers on (on=1) or alignment over (on=0); a hang ends the run
	task automatic settle(input bit on, input int bound, output int n);
		n = 0;
		do begin
			step(1);
			n++;
		end while ((on ? diff_on === '0 : align_active !== 1'b0) && n < bound);
		if (n >= bound) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, n, bound);
			tally_and_finish();
		end
	endtask

	initial begin
		int n;
		int moves;
		int t [3];
		moves = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		fork
			settle(1'b1, 300, n);
			repeat (15) begin
				step(1);
				if (nvm_load_req === 1'b1) moves++;
			end
		join
		chk_span(n, POR_T - 2, POR_T + 24);
		chk_span(moves, 1, 1);
		align_host_model_i.set_select(1'b0);
		$display("test power_on done");

		chk_reg(A_OUT_CTL0, OUT_CTL_RST);
		chk_reg(12'h3ff, 8'h00);
		bus_wr(A_OUT_CTL0 + 12'h002, 8'h62);
		bus_wr(A_OUT_CTL0 + 12'h001, 8'h65);
		bus_wr(A_DIV_MN0 + 12'h005, 8'h04);
		chk_reg(A_DIV_MN0 + 12'h005, 8'h04);
		step(3);
		chk_val(diff_swing[5:0], 6'b011010);
		chk_val(diff_safe_pd, 12'h03a);
		chk_val(diff_on[5:0], 6'b000101);
		bus_wr(A_OUT_CTL0, 8'h70);
		step(3);
		chk_val({cmos_a_oe[0], cmos_b_oe[0]}, 2'b11);
		bus_wr(A_OUT_CTL0, 8'h30);
		step(3);
		chk_val({cmos_a_oe[0], cmos_b_oe[0]}, 2'b10);
		bus_wr(A_OUT_CTL0, OUT_CTL_RST);
		bus_wr(A_OUT_CTL0 + 12'h001, OUT_CTL_RST);
		bus_wr(A_DIV_MN0 + 12'h005, 8'h00);
		$display("test driver_config done");

		bus_wr(A_OUT_CTL0 + 12'h001, 8'h6c);
		bus_wr(A_OUT_CTL0 + 12'h002, 8'he4);
		for (int c = 0; c < NUM_CH; c++) begin
			bus_wr(A_DIV_MN0 + 12'(DIV_STRIDE * c), 8'h11);
			bus_wr(A_DIV_MN0 + 12'(DIV_STRIDE * c + 1), phase_tab[c]);
		end
		moves = 0;
		fork
			align_host_model_i.pulse_pin(0, 16);
			begin
				step(4);
				repeat (10) begin
					n = diff_out[9];
					step(1);
					if (diff_out[9] !== n[0]) moves++;
				end
				chk_val(diff_out[8:0], 9'h1c2);
				chk_val(cmos_a[8:0], 9'h1c2);
				chk_val(cmos_b[8:0], 9'h1c4);
			end
		join
		chk_span(moves, 1, 10);
		t = '{0, 0, 0};
		for (int k = 1; k <= 80; k++) begin
			step(1);
			for (int c = 0; c < 3; c++) begin
				if (t[c] == 0 && diff_out[3 * c] !== (c == 2)) t[c] = k;
			end
		end
		chk_span(t[0], 16, 20);
		chk_span(t[1] - t[0], 5, 5);
		chk_span(t[2] - t[0], 7, 7);
		$display("test pin_align done");

		for (int b = 1; b <= 2; b++) begin
			bus_wr(A_DIST_CTL, 8'(b));
			step(3);
			chk_val({align_active, diff_total_pd}, 2'b00);
			bus_wr(A_UPDATE, 8'h01);
			step(3);
			chk_val(b == 1 ? {12'h000, align_active} : {diff_total_pd, diff_on},
				b == 1 ? 13'h0001 : 13'h1000);
			bus_wr(A_DIST_CTL, 8'h00);
			bus_wr(A_UPDATE, 8'h01);
			settle(1'b0, 80, n);
			chk_span(n, 1, 79);
		end
		$display("test soft_align done");

		bus_wr(A_OUT_CTL0, 8'h00);
		bus_wr(A_SERIAL_CFG, 8'ha5);
		chk_reg(A_SERIAL_CFG, 8'ha5);
		chk_reg(A_OUT_CTL0, OUT_CTL_RST);
		align_host_model_i.serial_tick();
		step(4);
		chk_reg(A_SERIAL_CFG, 8'h81);
		settle(1'b0, 80, n);
		$display("test soft_reset done");

		for (int v = 1; v >= 0; v--) begin
			align_host_model_i.set_select(v[0]);
			bus_wr(A_OUT_CTL0, 8'h00);
			align_host_model_i.pulse_pin(1, 8);
			step(4);
			settle(1'b1, 800, n);
			chk_span(n + 4, (v == 1 ? HW_N : 500) - 3, (v == 1 ? HW_N : 500) + 24);
			chk_reg(A_OUT_CTL0, OUT_CTL_RST);
			settle(1'b0, 80, n);
		end
		$display("test hard_reset done");

		align_host_model_i.pulse_pin(2, 8);
		settle(1'b0, 80, n);
		chk_span(n, 2, 79);
		align_host_model_i.pulse_pin(3, 6);
		settle(1'b0, 80, n);
		chk_span(n, 2, 79);
		$display("test sleep_and_cal done");
		tally_and_finish();
	end
endmodule
